// ==== io_delay_pkg.sv ====
// constants, timing figures and type definitions for the socketed i/o delay tuning port
//
// Overview of operation
// R1: direction one plus strobe raises delay by steps
// R2: direction zero plus strobe lowers delay by steps
// R3: sixteen-bit step count applied only after strobe
// R4: strobe applies configured delay change to line
// R5: user sets steps and direction before strobe
// R6: user waits for done before next strobe
// R7: done flag asserts when adjustment finishes
// R8: sixteen-bit readback of current delay taps
// R9: increments blocked once tap reaches 511
// R10: decrements blocked at alignment minimum tap
// R11: ready only after successful configuration
// R12: errors reported on signed 32-bit output
// R13: single-ended enable one drives write value
// R14: single-ended enable zero releases, reports level
// R15: trigger enable one drives trigger write value
// R16: trigger enable zero reports received level
// R17: serialize and deserialize 8-bit channel words
// R18: inversion control shifts clock half period
// R19: clocks on line 13, plus 29/54 all-out
// R20: strobe edge-triggered; done low until finish
package io_delay_pkg;

    // --------
    // delay tap limits
    // --------
    localparam logic [15:0] TAP_MAX       = 16'h01ff;  // upper tap bound, 511
    localparam logic [15:0] TAP_ALIGN_MIN = 16'h0008;  // alignment minimum, plain default
    localparam logic [15:0] TAP_RESET     = 16'h0008;  // tap after reset, sits at minimum
    localparam int          NUM_LINES     = 2;         // index 0 transmit, 1 receive

    // --------
    // timing
    // --------
    localparam int CLK_PERIOD_PS    = 5000;      // 200 mhz system clock
    localparam int CONFIG_TIME_NS   = 1000;      // least settle time before ready
    localparam int LINK_WATCH_NS    = 1000;      // longest gap between link clock rising edges
    localparam int CONFIG_CYCLES    = (CONFIG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LINK_WATCH_CYCLES = (LINK_WATCH_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [11:0] CONFIG_COUNT = 12'(CONFIG_CYCLES);
    localparam logic [11:0] WATCH_COUNT  = 12'(LINK_WATCH_CYCLES);

    // --------
    // serial word shape and error codes
    // --------
    localparam logic [2:0]         SER_LAST_BIT = 3'h7;            // bits left after first
    localparam logic signed [31:0] ERR_NONE     = 32'sh00000000;
    localparam logic signed [31:0] ERR_LINK_CLK = 32'shfffffff0;   // link clock lost

    typedef enum logic [1:0] {
        CFG_WAIT,
        CFG_READY,
        CFG_FAULT
    } cfg_state_t;

endpackage

// ==== io_delay_port.sv ====
// socketed i/o port: line delay tuning, direction control, 8-bit serdes and clock outputs
`timescale 1ns/100ps
`default_nettype none

module io_delay_port (
    input  wire logic          clk,
    input  wire logic          rst_n,
    // configuration selects
    input  wire logic          half_in_half_out_config,
    input  wire logic          all_out_config,
    // status
    output logic               io_ready,
    output logic signed [31:0] io_error,
    // transmit delay adjust
    input  wire logic [15:0]   tx_delay_steps,
    input  wire logic          tx_delay_increment,
    input  wire logic          tx_delay_strobe,
    output logic [15:0]        tx_delay_value,
    output logic               tx_delay_done,
    // receive delay adjust
    input  wire logic [15:0]   rx_delay_steps,
    input  wire logic          rx_delay_increment,
    input  wire logic          rx_delay_strobe,
    output logic [15:0]        rx_delay_value,
    output logic               rx_delay_done,
    // single-ended line
    input  wire logic          single_end_drive_en,
    input  wire logic          single_end_write_val,
    output logic               single_end_read_val,
    input  wire logic          single_end_pin_in,
    output logic               single_end_pin_out,
    output logic               single_end_pin_oe,
    // differential trigger line
    input  wire logic          diff_trigger_drive_en,
    input  wire logic          diff_trigger_write_val,
    output logic               diff_trigger_read_val,
    input  wire logic          trigger_line_in,
    output logic               trigger_line_out,
    output logic               trigger_line_oe,
    // differential data channel
    input  wire logic          link_clk,
    input  wire logic [7:0]    write_word,
    input  wire logic          write_word_valid,
    output logic               write_word_ready,
    output logic [7:0]         read_word,
    output logic               read_word_valid,
    output logic               data_line_out,
    input  wire logic          data_line_in,
    // generated clock outputs
    input  wire logic          gen_clock_invert_line13,
    input  wire logic          gen_clock_invert_line29,
    input  wire logic          gen_clock_invert_line54,
    output logic               gen_clock_line13,
    output logic               gen_clock_line29,
    output logic               gen_clock_line54
);

    // --------
    // helpers
    // --------

    // one tap move, held inside the limits; a blocked move keeps the tap
    function automatic logic [15:0] tap_step(input logic [15:0] tap, input logic up);
        logic [15:0] res;
        res = tap;
        if (up) begin
            if (tap < io_delay_pkg::TAP_MAX) begin                  // R9
                res = tap + 16'h0001;                               // R1
            end
        end else begin
            if (tap > io_delay_pkg::TAP_ALIGN_MIN) begin            // R10
                res = tap - 16'h0001;                               // R2
            end
        end
        return res;
    endfunction

    // --------
    // input synchronisers
    // --------
    logic [1:0] link_clk_sync;     // link clock, two stages
    logic [1:0] data_in_sync;      // serial data in
    logic [1:0] se_in_sync;        // single-ended pin level
    logic [1:0] trig_in_sync;      // trigger pin level
    logic       link_clk_prev;     // last synced link level, for edges
    logic       link_rise;         // combinational edge strobe
    logic       link_fall;

    // all outside levels pass two flops; only stage one is read by stage two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_clk_sync <= 2'h0;
            data_in_sync  <= 2'h0;
            se_in_sync    <= 2'h0;
            trig_in_sync  <= 2'h0;
            link_clk_prev <= 1'b0;
        end else begin
            link_clk_sync <= {link_clk_sync[0], link_clk};
            data_in_sync  <= {data_in_sync[0], data_line_in};
            se_in_sync    <= {se_in_sync[0], single_end_pin_in};
            trig_in_sync  <= {trig_in_sync[0], trigger_line_in};
            link_clk_prev <= link_clk_sync[1];
        end
    end

    assign link_rise = link_clk_sync[1] & ~link_clk_prev;
    assign link_fall = ~link_clk_sync[1] & link_clk_prev;

    // --------
    // configuration, ready and error status
    // --------
    io_delay_pkg::cfg_state_t cfg_state;   // bring-up state
    logic [11:0]              cfg_count;   // settle counter
    logic [11:0]              watch_count; // cycles since last link rising edge

    // ready needs the settle time and a live link clock; a stall drops it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_state   <= io_delay_pkg::CFG_WAIT;
            cfg_count   <= 12'h000;
            watch_count <= 12'h000;
            io_ready    <= 1'b0;
            io_error    <= io_delay_pkg::ERR_NONE;
        end else begin
            if (link_rise) begin
                watch_count <= 12'h000;
            end else if (watch_count != io_delay_pkg::WATCH_COUNT) begin
                watch_count <= watch_count + 12'h001;
            end
            case (cfg_state)
                io_delay_pkg::CFG_WAIT: begin
                    // wait settle time, then demand a live link clock
                    if (cfg_count != io_delay_pkg::CONFIG_COUNT) begin
                        cfg_count <= cfg_count + 12'h001;
                    end else if (watch_count == io_delay_pkg::WATCH_COUNT) begin
                        cfg_state <= io_delay_pkg::CFG_FAULT;
                        io_error  <= io_delay_pkg::ERR_LINK_CLK;              // R12
                    end else if (link_rise) begin
                        cfg_state <= io_delay_pkg::CFG_READY;
                        io_ready  <= 1'b1;                                    // R11
                    end
                end
                io_delay_pkg::CFG_READY: begin
                    // link clock gone: report and drop ready
                    if (watch_count == io_delay_pkg::WATCH_COUNT) begin
                        cfg_state <= io_delay_pkg::CFG_FAULT;
                        io_ready  <= 1'b0;                                    // R11
                        io_error  <= io_delay_pkg::ERR_LINK_CLK;              // R12
                    end
                end
                default: begin
                    // fault clears itself when the clock returns
                    if (link_rise) begin
                        cfg_state <= io_delay_pkg::CFG_READY;
                        io_ready  <= 1'b1;                                    // R11
                        io_error  <= io_delay_pkg::ERR_NONE;
                    end
                end
            endcase
        end
    end

    // --------
    // delay tuning, one engine per line
    // --------
    logic [15:0] tap     [io_delay_pkg::NUM_LINES];  // current tap count
    logic [15:0] left    [io_delay_pkg::NUM_LINES];  // steps still to take
    logic        up      [io_delay_pkg::NUM_LINES];  // latched direction
    logic        busy    [io_delay_pkg::NUM_LINES];  // adjustment running
    logic        done    [io_delay_pkg::NUM_LINES];  // completion flag
    logic        stb_prev[io_delay_pkg::NUM_LINES];  // strobe history
    logic [15:0] steps_in[io_delay_pkg::NUM_LINES];
    logic        incr_in [io_delay_pkg::NUM_LINES];
    logic        stb_in  [io_delay_pkg::NUM_LINES];

    assign steps_in[0] = tx_delay_steps;
    assign steps_in[1] = rx_delay_steps;
    assign incr_in[0]  = tx_delay_increment;
    assign incr_in[1]  = rx_delay_increment;
    assign stb_in[0]   = tx_delay_strobe;
    assign stb_in[1]   = rx_delay_strobe;

    // one tap per clock; blocked steps still count, so done time is fixed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < io_delay_pkg::NUM_LINES; i++) begin
                tap[i]      <= io_delay_pkg::TAP_RESET;
                left[i]     <= 16'h0000;
                up[i]       <= 1'b0;
                busy[i]     <= 1'b0;
                done[i]     <= 1'b1;
                stb_prev[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < io_delay_pkg::NUM_LINES; i++) begin
                stb_prev[i] <= stb_in[i];
                if (busy[i]) begin
                    // strobes while busy are ignored
                    if (left[i] == 16'h0000) begin
                        busy[i] <= 1'b0;
                        done[i] <= 1'b1;                                      // R7
                    end else begin
                        tap[i]  <= tap_step(tap[i], up[i]);                   // R4
                        left[i] <= left[i] - 16'h0001;
                    end
                end else if (stb_in[i] && !stb_prev[i]) begin                 // R20
                    // latch request only on the strobe edge
                    left[i] <= steps_in[i];                                   // R3
                    up[i]   <= incr_in[i];                                    // R1 R2
                    busy[i] <= 1'b1;
                    done[i] <= 1'b0;                                          // R20
                end
            end
        end
    end

    assign tx_delay_value = tap[0];                                           // R8
    assign rx_delay_value = tap[1];                                           // R8
    assign tx_delay_done  = done[0];
    assign rx_delay_done  = done[1];

    // --------
    // single-ended and trigger line direction
    // --------

    // driven values are registered so the pins come straight from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            single_end_pin_out    <= 1'b0;
            single_end_pin_oe     <= 1'b0;
            single_end_read_val   <= 1'b0;
            trigger_line_out      <= 1'b0;
            trigger_line_oe       <= 1'b0;
            diff_trigger_read_val <= 1'b0;
        end else begin
            single_end_pin_out    <= single_end_write_val;                    // R13
            single_end_pin_oe     <= single_end_drive_en;                     // R13 R14
            single_end_read_val   <= se_in_sync[1];                           // R14
            trigger_line_out      <= diff_trigger_write_val;                  // R15
            trigger_line_oe       <= diff_trigger_drive_en;                   // R15 R16
            diff_trigger_read_val <= trig_in_sync[1];                         // R16
        end
    end

    // --------
    // two-entry write buffer
    // --------
    logic [7:0] fifo_mem[2];   // buffer storage
    logic       fifo_wr;       // write index
    logic       fifo_rd;       // read index
    logic [1:0] fifo_cnt;      // words held
    logic [1:0] next_fifo_cnt;
    logic       push;
    logic       pop;
    logic [2:0] ser_left;      // bits still to shift out
    logic [7:0] ser_sh;        // outgoing shift register

    // ready is registered, so it reflects room after this cycle
    assign push = write_word_valid & write_word_ready;
    assign pop  = link_rise & (ser_left == 3'h0) & (fifo_cnt != 2'h0);

    always_comb begin
        next_fifo_cnt = fifo_cnt;
        if (push && !pop) begin
            next_fifo_cnt = fifo_cnt + 2'h1;
        end else if (pop && !push) begin
            next_fifo_cnt = fifo_cnt - 2'h1;
        end
    end

    // storage and pointers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_mem[0]      <= 8'h00;
            fifo_mem[1]      <= 8'h00;
            fifo_wr          <= 1'b0;
            fifo_rd          <= 1'b0;
            fifo_cnt         <= 2'h0;
            write_word_ready <= 1'b0;
        end else begin
            if (push) begin
                fifo_mem[fifo_wr] <= write_word;
                fifo_wr           <= ~fifo_wr;
            end
            if (pop) begin
                fifo_rd <= ~fifo_rd;
            end
            fifo_cnt         <= next_fifo_cnt;
            write_word_ready <= (next_fifo_cnt != 2'h2);
        end
    end

    // --------
    // serializer, msb first, one bit per link rising edge
    // --------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ser_left      <= 3'h0;
            ser_sh        <= 8'h00;
            data_line_out <= 1'b0;
        end else if (link_rise) begin
            if (ser_left != 3'h0) begin
                data_line_out <= ser_sh[7];                                   // R17
                ser_sh        <= {ser_sh[6:0], 1'b0};
                ser_left      <= ser_left - 3'h1;
            end else if (pop) begin
                data_line_out <= fifo_mem[fifo_rd][7];                        // R17
                ser_sh        <= {fifo_mem[fifo_rd][6:0], 1'b0};
                ser_left      <= io_delay_pkg::SER_LAST_BIT;
            end else begin
                // idle: line rests low between words
                data_line_out <= 1'b0;
            end
        end
    end

    // --------
    // deserializer, samples on link falling edge mid-bit
    // --------
    logic [7:0] des_sh;    // incoming shift register
    logic [2:0] des_cnt;   // bits gathered

    // no word framing on the line: words align from reset onward
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            des_sh          <= 8'h00;
            des_cnt         <= 3'h0;
            read_word       <= 8'h00;
            read_word_valid <= 1'b0;
        end else begin
            read_word_valid <= 1'b0;
            if (link_fall) begin
                des_sh  <= {des_sh[6:0], data_in_sync[1]};
                des_cnt <= des_cnt + 3'h1;
                if (des_cnt == io_delay_pkg::SER_LAST_BIT) begin
                    read_word       <= {des_sh[6:0], data_in_sync[1]};        // R17
                    read_word_valid <= 1'b1;
                end
            end
        end
    end

    // --------
    // generated clock outputs
    // --------

    // follows the sampled link clock; inversion swaps phase by half a period
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gen_clock_line13 <= 1'b0;
            gen_clock_line29 <= 1'b0;
            gen_clock_line54 <= 1'b0;
        end else begin
            // line 13 runs in half-in and all-out builds
            gen_clock_line13 <= (half_in_half_out_config | all_out_config)
                              & (link_clk_sync[1] ^ gen_clock_invert_line13); // R18 R19
            gen_clock_line29 <= all_out_config
                              & (link_clk_sync[1] ^ gen_clock_invert_line29); // R18 R19
            gen_clock_line54 <= all_out_config
                              & (link_clk_sync[1] ^ gen_clock_invert_line54); // R18 R19
        end
    end

endmodule

`default_nettype wire

// ==== io_delay_checker.sv ====
// checker: delay handshake, tap limits, pin direction and clock gating
`timescale 1ns/100ps
`default_nettype none
module io_delay_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        all_out_config,
    input wire logic        tx_delay_strobe,
    input wire logic        tx_delay_done,
    input wire logic [15:0] tx_delay_value,
    input wire logic        single_end_drive_en,
    input wire logic        single_end_write_val,
    input wire logic        single_end_pin_out,
    input wire logic        single_end_pin_oe,
    input wire logic        diff_trigger_read_val,
    input wire logic        trigger_line_in,
    input wire logic        gen_clock_line54,
    input wire logic        read_word_valid,
    input wire logic        write_word_ready
);
    // --------
    // one clock domain, reset is synchronous
    // --------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_done_falls: assert property ($rose(tx_delay_strobe) && tx_delay_done |=> !tx_delay_done)
        else $error("done held after strobe");
    a_done_bound: assert property (!tx_delay_done |-> ##[1:700] tx_delay_done)
        else $error("adjust never finished");
    a_tap_upper: assert property (tx_delay_value <= io_delay_pkg::TAP_MAX)
        else $error("tap above upper limit");
    a_tap_lower: assert property (tx_delay_value >= io_delay_pkg::TAP_ALIGN_MIN)
        else $error("tap below lower limit");
    a_se_drive: assert property (single_end_drive_en |=> single_end_pin_oe
        && single_end_pin_out == $past(single_end_write_val)) else $error("line not driven");
    a_se_release: assert property (!single_end_drive_en |=> !single_end_pin_oe)
        else $error("line still driven");
    // read side is two sync flops plus a register, so three cycles
    a_trig_read: assert property (diff_trigger_read_val == $past(trigger_line_in, 3))
        else $error("trigger level not reported");
    a_line54_off: assert property (!all_out_config |=> !gen_clock_line54)
        else $error("line 54 active without all-out");
    c_adjust: cover property ($fell(tx_delay_done));
    c_full: cover property ($fell(write_word_ready));
    c_word: cover property (read_word_valid);
endmodule
bind io_delay_port io_delay_checker chk (
    .clk, .rst_n, .all_out_config, .tx_delay_strobe, .tx_delay_done, .tx_delay_value,
    .single_end_drive_en, .single_end_write_val, .single_end_pin_out, .single_end_pin_oe,
    .diff_trigger_read_val, .trigger_line_in, .gen_clock_line54, .read_word_valid,
    .write_word_ready
);
`default_nettype wire

// ==== link_partner.sv ====
// link side model: link clock, a fixed serial word in, capture of the serial out
`timescale 1ns/100ps
`default_nettype none
module link_partner #(parameter logic [7:0] RX_WORD = 8'h69) (
    input  wire logic        run,
    input  wire logic        data_line_out,
    output logic             link_clk,
    output logic             data_line_in,
    output logic [31:0]      cap,
    output logic [5:0]       cnt
);
    logic [2:0] bit_idx = 3'h7;  // next bit to send, msb first
    initial begin
        link_clk = 1'b0;
        data_line_in = 1'b0;
        cap = 32'h00000000;
        cnt = 6'h00;
    end
    // held low until started, so the first edge the block sees is a rise
    always #24 if (run) link_clk = ~link_clk;
    // send on rises; capture starts at the first set bit, since the line idles low
    always @(posedge link_clk) begin
        data_line_in <= RX_WORD[bit_idx];
        bit_idx <= bit_idx - 3'h1;
        if (cnt != 6'h20 && (cnt != 6'h00 || data_line_out)) begin
            cap <= {cap[30:0], data_line_out};
            cnt <= cnt + 6'h01;
        end
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// bench: delay tuning, pin direction, clock outputs and serial words
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, se_ext = 1'b0, tr_ext = 1'b0;
    logic half_in_half_out_config = 1'b0, all_out_config = 1'b0, write_word_valid = 1'b0;
    logic single_end_drive_en = 1'b0, single_end_write_val = 1'b0;
    logic diff_trigger_drive_en = 1'b0, diff_trigger_write_val = 1'b0;
    logic gen_clock_invert_line13 = 1'b0, gen_clock_invert_line29 = 1'b0;
    logic gen_clock_invert_line54 = 1'b0;
    logic [7:0] write_word = 8'h00, read_word;
    logic [15:0] steps [2] = '{16'h0000, 16'h0000}, val [2];
    logic inc [2] = '{1'b0, 1'b0}, stb [2] = '{1'b0, 1'b0}, done [2];
    logic signed [31:0] io_error;
    logic io_ready, single_end_read_val, single_end_pin_out, single_end_pin_oe, link_clk;
    logic diff_trigger_read_val, trigger_line_out, trigger_line_oe, write_word_ready;
    logic read_word_valid, data_line_out, data_line_in, gen_clock_line13;
    logic gen_clock_line29, gen_clock_line54;
    logic [31:0] cap;
    logic [5:0] cnt;
    int n_mismatch = 0, comparisons = 0;
    // far side drives the pin when released
    wire logic single_end_pin_in = single_end_pin_oe ? single_end_pin_out : se_ext;
    wire logic trigger_line_in = trigger_line_oe ? trigger_line_out : tr_ext;
    always #2.5 clk = ~clk;
    io_delay_port DUT (
        .clk, .rst_n, .half_in_half_out_config, .all_out_config, .io_ready, .io_error,
        .tx_delay_steps(steps[0]), .tx_delay_increment(inc[0]), .tx_delay_strobe(stb[0]),
        .tx_delay_value(val[0]), .tx_delay_done(done[0]),
        .rx_delay_steps(steps[1]), .rx_delay_increment(inc[1]), .rx_delay_strobe(stb[1]),
        .rx_delay_value(val[1]), .rx_delay_done(done[1]),
        .single_end_drive_en, .single_end_write_val, .single_end_read_val, .single_end_pin_in,
        .single_end_pin_out, .single_end_pin_oe, .diff_trigger_drive_en, .diff_trigger_write_val,
        .diff_trigger_read_val, .trigger_line_in, .trigger_line_out, .trigger_line_oe,
        .link_clk, .write_word, .write_word_valid, .write_word_ready, .read_word,
        .read_word_valid, .data_line_out, .data_line_in, .gen_clock_invert_line13,
        .gen_clock_invert_line29, .gen_clock_invert_line54, .gen_clock_line13,
        .gen_clock_line29, .gen_clock_line54);
    link_partner #(.RX_WORD(8'h69)) partner (.run, .data_line_out, .link_clk, .data_line_in,
        .cap, .cnt);
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d of %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one adjustment; ghost adds a strobe while busy, which must be ignored
    task automatic adj(input int ln, input logic up, input logic [15:0] n, input logic ghost,
            input logic [15:0] exp);
        int c = 0;
        @(posedge clk);
        steps[ln] <= n;
        inc[ln] <= up;
        @(posedge clk);
        stb[ln] <= 1'b1;
        @(posedge clk);
        stb[ln] <= 1'b0;
        if (ghost) begin
            @(posedge clk);
            stb[ln] <= 1'b1;
            inc[ln] <= ~up;
            @(posedge clk);
            stb[ln] <= 1'b0;
            c = 2;
        end
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (done[ln] !== 1'b1 && c < 1000);
        chk("adjust cycles", 32'(n) + 32'd1, c);
        chk("tap value", {16'h0000, exp}, {16'h0000, val[ln]});
    endtask
    // every enable and level pair; the outside drives the opposite level
    task automatic t_pins;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            single_end_drive_en <= k[1];
            single_end_write_val <= k[0];
            diff_trigger_drive_en <= k[1];
            diff_trigger_write_val <= k[0];
            se_ext <= ~k[0];
            tr_ext <= ~k[0];
            repeat (6) @(posedge clk);
            #1;
            chk("single-ended oe", k[1], single_end_pin_oe);
            chk("single-ended read", 1'(k[0] ~^ k[1]), single_end_read_val);
            chk("trigger oe", k[1], trigger_line_oe);
            chk("trigger read", 1'(k[0] ~^ k[1]), diff_trigger_read_val);
        end
    endtask
    // gated and inverted clock outputs under both configurations
    task automatic t_clocks;
        int hi13 = 0, hi29 = 0, same = 0;
        @(posedge clk);
        half_in_half_out_config <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            #1;
            hi13 += (gen_clock_line13 === 1'b1);
            hi29 += (gen_clock_line29 === 1'b1);
        end
        chk("line 13 toggles", 1, hi13 > 4 && hi13 < 36);
        chk("line 29 idle", 0, hi29);
        @(posedge clk);
        all_out_config <= 1'b1;
        gen_clock_invert_line13 <= 1'b1;
        repeat (8) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            #1;
            same += (gen_clock_line13 === gen_clock_line29);
        end
        chk("line 13 inverted against 29", 0, same);
    endtask
    // fill the buffer until it refuses, then compare the serial capture
    task automatic t_stream;
        logic [7:0] w [4] = '{8'ha5, 8'h3c, 8'hc3, 8'h96};
        logic full = 1'b0;
        int c = 0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            write_word <= w[i];
            write_word_valid <= 1'b1;
            do begin
                @(posedge clk);
                full |= (write_word_ready !== 1'b1);
            end while (write_word_ready !== 1'b1);
        end
        write_word_valid <= 1'b0;
        chk("buffer refused", 1, full);
        for (c = 0; c < 5000 && cnt != 6'h20; c++) @(posedge clk);
        chk("serial words", {w[0], w[1], w[2], w[3]}, cap);
        for (c = 0; c < 200 && read_word_valid !== 1'b1; c++) begin
            @(posedge clk);
            #1;
        end
        chk("read word", 8'h69, read_word);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        run <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("tap after reset", 16'h0008, val[0]);
        chk("ready held low", 0, io_ready);
        for (int c = 0; c < 1000 && io_ready !== 1'b1; c++) @(posedge clk);
        #1;
        chk("ready", 1, io_ready);
        chk("error code", 0, io_error);
        adj(0, 1'b1, 16'h0005, 1'b0, 16'h000d);
        adj(0, 1'b0, 16'h000a, 1'b0, 16'h0008);
        adj(0, 1'b1, 16'h0258, 1'b0, 16'h01ff);
        adj(0, 1'b0, 16'h0000, 1'b0, 16'h01ff);
        adj(1, 1'b1, 16'h0014, 1'b1, 16'h001c);
        t_pins;
        t_clocks;
        t_stream;
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        stop_test;
    end
endmodule
`default_nettype wire
